// ### acs_pkg.sv
package acs_pkg;
  // ----------------------------------------
  // Revisions
  // ----------------------------------------
  localparam logic [1:0] REV_FIRST  = 2'h0;  // Earliest silicon
  localparam logic [1:0] REV_SECOND = 2'h1;  // Second silicon
  localparam logic [1:0] REV_LATEST = 2'h2;  // Current silicon
  // ----------------------------------------
  // Compute modes
  // ----------------------------------------
  localparam logic [2:0] MODE_BASIC = 3'h0;  // Plain conversion
  localparam logic [2:0] MODE_BURST = 3'h3;  // Burst average
  // ----------------------------------------
  // Widths, limits, timing
  // ----------------------------------------
  localparam int          CNT_W     = 8;      // Counter widths
  localparam logic [7:0]  ACQ_MAX   = 8'hff;  // Largest acquisition count
  localparam logic [7:0]  CNT_ONE   = 8'h01;  // Counter stall value
  localparam int          SYS_MHZ   = 50;     // System clock rate
  localparam int          FAST_MHZ  = 40;     // Fast oscillator limit
  localparam logic [7:0]  CONV_CYC  = 8'h0e;  // Clocks per conversion
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV, ST_DONE, ST_HUNG} acs_state_type;
endpackage : acs_pkg

// ### acs_tick_if.sv
`timescale 1ns/1ps
// Conversion clock tick between sequencer and divider
interface acs_tick_if;
  logic       use_rc;   // Dedicated RC clock selected
  logic [7:0] divide;   // System clock divider
  logic       tick;     // One conversion clock period
  modport src (input use_rc, input divide, output tick);
  modport snk (output use_rc, output divide, input tick);
endinterface : acs_tick_if

// ### acs_tick_gen.sv
`timescale 1ns/1ps
// Conversion clock tick generator
module acs_tick_gen (
  // Clock and reset
  input wire logic  CLOCK,
  input wire logic  RST_N,
  // Tick link
  acs_tick_if.src   tk
);
  typedef struct packed {
    logic [7:0] cnt;  // Divider count
    logic       tick; // Tick out
  } acs_tick_type;
  acs_tick_type st_reg, st_next;

  // Divider; RC clock modelled as fixed division by two
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 8'h00) begin
      st_next.tick = 1'b1;
      st_next.cnt  = tk.use_rc ? 8'h01 : tk.divide;
    end else begin
      st_next.cnt  = st_reg.cnt - 8'h01;
    end
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;
endmodule : acs_tick_gen

// ### acs_sequencer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Converter sequencer
// ----------------------------------------
// Errata this block models, and the software workarounds for them
// R1: Earliest revision: RC-clocked results are corrupted
// R2: Software keeps conversion clock period long enough
// R3: Burst, non-repeat, double sample: counter stalls
// R4: Software uses repeat run plus stop-on-irq
// R5: Sleep option: single sample burst averaging
// R6: Early revisions, fast system clock: go hangs
// R7: Software selects RC clock on early revisions
// R8: Double sample zero timing inserts maximum acquisition
// R9: Zero timing: first conversion has no precharge or acquisition
// R10: Software avoids delay by single conversions
// R11: Burst counts completed runs, interrupt at target
module acs_sequencer #(
  parameter logic [1:0] REVISION = acs_pkg::REV_LATEST,  // Silicon revision modelled
  parameter int         OSC_MHZ  = acs_pkg::SYS_MHZ      // System oscillator rate
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // Configuration
  input  wire logic        DEDICATED_RC_CLOCK,
  input  wire logic [7:0]  CLOCK_DIVIDE,
  input  wire logic [2:0]  COMPUTE_MODE_FIELD,
  input  wire logic        REPEAT_RUN_ENABLE,
  input  wire logic        DOUBLE_SAMPLE_ENABLE,
  input  wire logic        STOP_ON_IRQ,
  input  wire logic [7:0]  PRECHARGE_CYCLES,
  input  wire logic [7:0]  ACQUISITION_CYCLES,
  input  wire logic [7:0]  REPEAT_TARGET,
  // Control
  input  wire logic        GO_SET,
  input  wire logic        GO_CLEAR,
  // Analog core
  input  wire logic [11:0] SAMPLE_IN,
  // Status
  output logic             GO_BUSY,
  output logic             PRECHARGE_ON,
  output logic             ACQUIRE_ON,
  output logic             CONVERT_ON,
  output logic [7:0]       REPEAT_COUNTER,
  output logic [11:0]      RESULT,
  output logic             RESULT_CORRUPT,
  output logic             CONVERTER_IRQ
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    acs_pkg::acs_state_type fsm;    // Sequence state
    logic [7:0]  timer;             // Phase timer in ticks
    logic        second;            // Second of a pair
    logic        go;                // Go bit
    logic [7:0]  count;             // Repeat counter
    logic [11:0] result;            // Last result
    logic        corrupt;           // Result invalid
    logic        irq;               // Interrupt pulse
  } acs_seq_type;
  acs_seq_type s_reg, s_next;

  acs_tick_if tk ();
  assign tk.use_rc = DEDICATED_RC_CLOCK;
  assign tk.divide = CLOCK_DIVIDE;

  acs_tick_gen u_tick (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .tk    (tk)
  );

  // Fault conditions, two on the earliest revision and one on the second, and burst mode decode
  logic rc_broken;    // RC clock gives bad results
  logic fast_hang;    // Fast oscillator hangs conversion
  logic burst;        // Burst average mode
  logic stall;        // Counter stall condition
  assign rc_broken = (REVISION == acs_pkg::REV_FIRST) && DEDICATED_RC_CLOCK; // see R1
  assign fast_hang = (REVISION != acs_pkg::REV_LATEST) && !DEDICATED_RC_CLOCK
                     && (OSC_MHZ > acs_pkg::FAST_MHZ);                        // see R6
  assign burst     = (COMPUTE_MODE_FIELD == acs_pkg::MODE_BURST);
  assign stall     = burst && !REPEAT_RUN_ENABLE && DOUBLE_SAMPLE_ENABLE;     // see R3

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next     = s_reg;
    s_next.irq = 1'b0;
    case (s_reg.fsm)
      acs_pkg::ST_IDLE: begin
        if (GO_SET) begin
          s_next.go     = 1'b1;
          s_next.second = 1'b0;
          // New run restarts the repeat count, no leftover from a stall
          s_next.count  = 8'h00;
          // First conversion honours programmed timing
          if (PRECHARGE_CYCLES != 8'h00) begin
            s_next.fsm   = acs_pkg::ST_PRE;
            s_next.timer = PRECHARGE_CYCLES;
          end else if (ACQUISITION_CYCLES != 8'h00) begin
            s_next.fsm   = acs_pkg::ST_ACQ;
            s_next.timer = ACQUISITION_CYCLES;
          end else begin
            s_next.fsm   = acs_pkg::ST_CONV; // see R9
            s_next.timer = acs_pkg::CONV_CYC;
          end
        end
      end
      acs_pkg::ST_PRE: begin
        if (GO_CLEAR) begin
          s_next.fsm = acs_pkg::ST_IDLE;
          s_next.go  = 1'b0;
        end else if (tk.tick) begin
          if (s_reg.timer > 8'h01) begin
            s_next.timer = s_reg.timer - 8'h01;
          end else if (ACQUISITION_CYCLES != 8'h00) begin
            s_next.fsm   = acs_pkg::ST_ACQ;
            s_next.timer = ACQUISITION_CYCLES;
          end else begin
            s_next.fsm   = acs_pkg::ST_CONV;
            s_next.timer = acs_pkg::CONV_CYC;
          end
        end
      end
      acs_pkg::ST_ACQ: begin
        if (GO_CLEAR) begin
          s_next.fsm = acs_pkg::ST_IDLE;
          s_next.go  = 1'b0;
        end else if (tk.tick) begin
          if (s_reg.timer > 8'h01) begin
            s_next.timer = s_reg.timer - 8'h01;
          end else begin
            s_next.fsm   = acs_pkg::ST_CONV;
            s_next.timer = acs_pkg::CONV_CYC;
          end
        end
      end
      acs_pkg::ST_CONV: begin
        if (GO_CLEAR) begin
          s_next.fsm = acs_pkg::ST_IDLE;
          s_next.go  = 1'b0;
        end else if (tk.tick) begin
          if (s_reg.timer > 8'h01) begin
            s_next.timer = s_reg.timer - 8'h01;
          end else if (fast_hang) begin
            s_next.fsm = acs_pkg::ST_HUNG; // see R6
          end else begin
            s_next.result  = SAMPLE_IN;
            s_next.corrupt = rc_broken; // see R1
            if (DOUBLE_SAMPLE_ENABLE && !s_reg.second) begin
              s_next.second = 1'b1;
              if (PRECHARGE_CYCLES == 8'h00 && ACQUISITION_CYCLES == 8'h00) begin
                s_next.fsm   = acs_pkg::ST_ACQ; // see R8
                s_next.timer = acs_pkg::ACQ_MAX;
              end else if (PRECHARGE_CYCLES != 8'h00) begin
                s_next.fsm   = acs_pkg::ST_PRE;
                s_next.timer = PRECHARGE_CYCLES;
              end else begin
                s_next.fsm   = acs_pkg::ST_ACQ;
                s_next.timer = ACQUISITION_CYCLES;
              end
            end else begin
              s_next.fsm = acs_pkg::ST_DONE;
            end
          end
        end
      end
      acs_pkg::ST_DONE: begin
        s_next.fsm = acs_pkg::ST_IDLE;
        s_next.go  = 1'b0;
        if (burst) begin
          // Burst accumulates one count per completed run
          if (!(stall && s_reg.count >= acs_pkg::CNT_ONE)) begin
            s_next.count = s_reg.count + 8'h01; // see R11
          end
          if (stall) begin
            // Counter parks at one; the burst ends with no irq
            s_next.go = 1'b0; // see R3
          end else if (s_next.count >= REPEAT_TARGET) begin
            s_next.irq = 1'b1; // see R11
            if (REPEAT_RUN_ENABLE && !STOP_ON_IRQ) begin
              // Repeat run opens a fresh burst
              s_next.go     = 1'b1;
              s_next.fsm    = acs_pkg::ST_CONV;
              s_next.timer  = acs_pkg::CONV_CYC;
              s_next.second = 1'b0;
              s_next.count  = 8'h00;
            end
          end else begin
            // Burst goes on by itself until the target is met
            s_next.go     = 1'b1;
            s_next.fsm    = acs_pkg::ST_CONV; // see R11
            s_next.timer  = acs_pkg::CONV_CYC;
            s_next.second = 1'b0;
          end
        end else begin
          s_next.irq = 1'b1;
          if (REPEAT_RUN_ENABLE && !STOP_ON_IRQ) begin
            s_next.go    = 1'b1;
            s_next.fsm   = acs_pkg::ST_CONV;
            s_next.timer = acs_pkg::CONV_CYC;
            s_next.second = 1'b0;
          end
        end
        if (s_next.irq && STOP_ON_IRQ) begin
          s_next.fsm = acs_pkg::ST_IDLE;
          s_next.go  = 1'b0;
        end
      end
      acs_pkg::ST_HUNG: begin
        // Go stays set until software clears it
        if (GO_CLEAR) begin
          s_next.fsm = acs_pkg::ST_IDLE;
          s_next.go  = 1'b0;
        end
      end
      default: s_next.fsm = acs_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg     <= '0;
      s_reg.fsm <= acs_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      GO_BUSY        <= 1'b0;
      PRECHARGE_ON   <= 1'b0;
      ACQUIRE_ON     <= 1'b0;
      CONVERT_ON     <= 1'b0;
      REPEAT_COUNTER <= 8'h00;
      RESULT         <= 12'h000;
      RESULT_CORRUPT <= 1'b0;
      CONVERTER_IRQ  <= 1'b0;
    end else begin
      GO_BUSY        <= s_next.go;
      PRECHARGE_ON   <= (s_next.fsm == acs_pkg::ST_PRE);
      ACQUIRE_ON     <= (s_next.fsm == acs_pkg::ST_ACQ);
      CONVERT_ON     <= (s_next.fsm == acs_pkg::ST_CONV);
      REPEAT_COUNTER <= s_next.count;
      RESULT         <= s_next.result;
      RESULT_CORRUPT <= s_next.corrupt;
      CONVERTER_IRQ  <= s_next.irq;
    end
  end
endmodule : acs_sequencer

// ### acs_assertions.sv
`timescale 1ns/1ps
module acs_chk #(
  parameter logic [1:0] REVISION = acs_pkg::REV_LATEST,  // Revision modelled
  parameter int         OSC_MHZ  = acs_pkg::SYS_MHZ      // Oscillator rate
) (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_N,
  // Configuration and control
  input wire logic       DEDICATED_RC_CLOCK,
  input wire logic [2:0] COMPUTE_MODE_FIELD,
  input wire logic       REPEAT_RUN_ENABLE,
  input wire logic       DOUBLE_SAMPLE_ENABLE,
  input wire logic [7:0] PRECHARGE_CYCLES,
  input wire logic [7:0] ACQUISITION_CYCLES,
  input wire logic       GO_CLEAR,
  // Status
  input wire logic       GO_BUSY,
  input wire logic       PRECHARGE_ON,
  input wire logic       ACQUIRE_ON,
  input wire logic       CONVERT_ON,
  input wire logic       RESULT_CORRUPT,
  input wire logic       CONVERTER_IRQ
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic zero_dbl;  // Double sample, no timing
  logic hang;      // Fast clock on early silicon
  logic stall;     // Burst, single run, double
  assign zero_dbl = DOUBLE_SAMPLE_ENABLE && PRECHARGE_CYCLES == 8'h00 && ACQUISITION_CYCLES == 8'h00;
  assign hang  = REVISION != acs_pkg::REV_LATEST && OSC_MHZ > acs_pkg::FAST_MHZ && !DEDICATED_RC_CLOCK;
  assign stall = COMPUTE_MODE_FIELD == acs_pkg::MODE_BURST && !REPEAT_RUN_ENABLE && DOUBLE_SAMPLE_ENABLE;
  // Long inserted acquisition
  sequence s_long_acq;
    ACQUIRE_ON [*8];
  endsequence
  // Conversion straight after start
  sequence s_direct;
    CONVERT_ON && !PRECHARGE_ON && !ACQUIRE_ON;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_irq_pulse: assert property (CONVERTER_IRQ |=> !CONVERTER_IRQ) else $error("irq wider than one cycle");
  a_phase_onehot: assert property ($onehot0({PRECHARGE_ON, ACQUIRE_ON, CONVERT_ON}))
    else $error("phases overlap");
  a_first_direct: assert property ($rose(GO_BUSY) && zero_dbl |-> s_direct) else $error("first not direct");
  a_long_acq: assert property ($rose(ACQUIRE_ON) && zero_dbl |-> s_long_acq) else $error("gap too short");
  a_stall_noirq: assert property (stall |-> !CONVERTER_IRQ) else $error("stalled burst irq");
  a_fast_hang: assert property (hang |-> !CONVERTER_IRQ) else $error("fast clock completed");
  a_rc_corrupt: assert property (CONVERTER_IRQ && DEDICATED_RC_CLOCK && REVISION == acs_pkg::REV_FIRST
    |-> RESULT_CORRUPT) else $error("rc result not flagged");
  a_clear_abort: assert property (GO_BUSY && GO_CLEAR |-> ##[1:3] !GO_BUSY) else $error("abort ignored");
endmodule : acs_chk
bind acs_sequencer acs_chk #(.REVISION(REVISION), .OSC_MHZ(OSC_MHZ)) acs_chk_i (
  .CLOCK                (CLOCK),
  .RST_N                (RST_N),
  .DEDICATED_RC_CLOCK   (DEDICATED_RC_CLOCK),
  .COMPUTE_MODE_FIELD   (COMPUTE_MODE_FIELD),
  .REPEAT_RUN_ENABLE    (REPEAT_RUN_ENABLE),
  .DOUBLE_SAMPLE_ENABLE (DOUBLE_SAMPLE_ENABLE),
  .PRECHARGE_CYCLES     (PRECHARGE_CYCLES),
  .ACQUISITION_CYCLES   (ACQUISITION_CYCLES),
  .GO_CLEAR             (GO_CLEAR),
  .GO_BUSY              (GO_BUSY),
  .PRECHARGE_ON         (PRECHARGE_ON),
  .ACQUIRE_ON           (ACQUIRE_ON),
  .CONVERT_ON           (CONVERT_ON),
  .RESULT_CORRUPT       (RESULT_CORRUPT),
  .CONVERTER_IRQ        (CONVERTER_IRQ)
);

// ### acs_analog_model.sv
`timescale 1ns/1ps
// Sample-and-hold: valid only while converting
module acs_analog_model (
  // Phase and level
  input  wire logic        CONVERT_ON,
  input  wire logic [11:0] LEVEL,
  // Held sample
  output logic [11:0]      SAMPLE_IN
);
  // Outside conversion show the inverse
  assign SAMPLE_IN = CONVERT_ON ? LEVEL : ~LEVEL;
endmodule : acs_analog_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {logic [2:0] md; logic ct, ds, so; logic [7:0] pr, aq, tg, ei, ec;} acs_row_type;
  logic clock = 1'b0, rst_n = 1'b0, ct = 1'b0, ds = 1'b0, so = 1'b0, gs = 1'b0, gc = 1'b0;
  logic rc = 1'b1;  // RC conversion clock on fast early silicon
  logic [2:0] md = 3'h0;
  logic [7:0] pr = 8'h00, aq = 8'h00, tg = 8'h00, dv = 8'h00, cnt;
  logic [11:0] lv = 12'h000, smp, res;
  logic busy, p_on, a_on, c_on, bad, irq;
  int fail_count = 0, check_count = 0, irqs, acqs, pres;
  acs_row_type rows [5] = '{
    '{acs_pkg::MODE_BASIC, 1'b0, 1'b0, 1'b0, 8'h02, 8'h03, 8'h00, 8'h01, 8'h00},  // Single conversion
    '{acs_pkg::MODE_BASIC, 1'b0, 1'b1, 1'b0, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00},
    '{acs_pkg::MODE_BURST, 1'b0, 1'b0, 1'b0, 8'h00, 8'h01, 8'h03, 8'h01, 8'h03},  // Sleep burst
    '{acs_pkg::MODE_BURST, 1'b0, 1'b1, 1'b0, 8'h00, 8'h01, 8'h03, 8'h00, 8'h01},  // Stalled burst
    '{acs_pkg::MODE_BURST, 1'b1, 1'b1, 1'b1, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02}}; // Repeat and stop
  // Early silicon to reach both defects
  acs_sequencer #(.REVISION(acs_pkg::REV_FIRST)) acs_sequencer_i (
    .CLOCK(clock), .RST_N(rst_n), .DEDICATED_RC_CLOCK(rc), .CLOCK_DIVIDE(dv),
    .COMPUTE_MODE_FIELD(md), .REPEAT_RUN_ENABLE(ct), .DOUBLE_SAMPLE_ENABLE(ds), .STOP_ON_IRQ(so),
    .PRECHARGE_CYCLES(pr), .ACQUISITION_CYCLES(aq), .REPEAT_TARGET(tg), .GO_SET(gs), .GO_CLEAR(gc),
    .SAMPLE_IN(smp), .GO_BUSY(busy), .PRECHARGE_ON(p_on), .ACQUIRE_ON(a_on), .CONVERT_ON(c_on),
    .REPEAT_COUNTER(cnt), .RESULT(res), .RESULT_CORRUPT(bad), .CONVERTER_IRQ(irq));
  acs_analog_model acs_analog_model_i (.CONVERT_ON(c_on), .LEVEL(lv), .SAMPLE_IN(smp));
  // 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Start one run, count irq and acquire cycles until idle
  task automatic run;
    int n;
    irqs = 0;
    acqs = 0;
    pres = 0;
    @(posedge clock) gs <= 1'b1;
    @(posedge clock) gs <= 1'b0;
    for (n = 0; n < 3000; n++) begin
      #1;
      irqs += int'(irq === 1'b1);
      acqs += int'(a_on === 1'b1);
      pres += int'(p_on === 1'b1);
      if (busy !== 1'b1) break;
      @(posedge clock);
    end
    if (n == 3000) begin
      fail_count++;
      wrap_up();
    end
  endtask : run
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    #1;
    check(res, 12'h000);
    check({9'h000, busy, irq, bad}, 12'h000);
    check(12'(cnt), 12'h000);
    @(posedge clock) rst_n <= 1'b1;
    // Table rows, dedicated RC clock
    foreach (rows[i]) begin
      @(posedge clock) {md, ct, ds, so, pr, aq, tg, lv} <=
        {rows[i].md, rows[i].ct, rows[i].ds, rows[i].so, rows[i].pr, rows[i].aq, rows[i].tg, 12'h5a0 + 12'(i)};
      run();
      check(12'(irqs), 12'(rows[i].ei));
      if (md == acs_pkg::MODE_BURST) check(12'(cnt), 12'(rows[i].ec));
      check(res, 12'h5a0 + 12'(i));
      check(12'(pres > 0), 12'(rows[i].pr != 8'h00));
      if (irqs > 0) check(12'(bad), 12'h001);
    end
    // Double sample with no timing: long gap
    @(posedge clock) {md, ct, ds, so, pr, aq} <= {acs_pkg::MODE_BASIC, 3'b010, 16'h0000};
    run();
    check(12'(irqs), 12'h001);
    check(12'(pres), 12'h000);
    check(12'(acqs >= 508 && acqs <= 512), 12'h001);
    // No precharge with a chosen acquisition: short gap
    @(posedge clock) aq <= 8'h03;
    run();
    check(12'(irqs), 12'h001);
    check(12'(acqs >= 10 && acqs <= 12), 12'h001);
    // Fast system clock on early silicon hangs; 4 us conversion clock period
    @(posedge clock) {rc, ds, aq, dv} <= {2'b00, 8'h00, 8'hc7};
    @(posedge clock) gs <= 1'b1;
    @(posedge clock) gs <= 1'b0;
    repeat (200) @(posedge clock);
    #1;
    check({9'h000, busy, irq, c_on}, 12'h005);
    repeat (3000) @(posedge clock);
    #1;
    check({9'h000, busy, irq, c_on}, 12'h004);
    @(posedge clock) gc <= 1'b1;
    @(posedge clock) gc <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(12'(busy), 12'h000);
    wrap_up();
  end
endmodule : tb_top
